// *** shared/sbst_pkg.sv ***
`default_nettype none
package sbst_pkg;
  // instruction register geometry and codes (codes not documented, kept as defaults)
  localparam int          IR_WIDTH        = 3;
  localparam logic [2:0]  OP_EXTEST       = 3'h0;
  localparam logic [2:0]  OP_IDCODE       = 3'h1;
  localparam logic [2:0]  OP_SAMPLE_Z     = 3'h2;
  localparam logic [2:0]  OP_SAMPLE       = 3'h4;
  localparam logic [2:0]  OP_BYPASS       = 3'h7;
  localparam logic [1:0]  IR_CAPTURE_PAT  = 2'h1;
  // identification register
  localparam int          ID_WIDTH        = 32;
  // boundary register geometry
  localparam int          BSR_WIDTH       = 109;
  localparam int          BSR_OE_CELL     = 108;
  localparam int          RESET_TMS_EDGES = 5;
  localparam int          FIFO_DEPTH      = 8;
  // controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAUSE_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_t;
endpackage
`default_nettype wire

// *** hw/sbst_fifo.sv ***
`default_nettype none
module sbst_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_enable,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sbst_fifo_t;
  sbst_fifo_t               st_r;
  sbst_fifo_t               st_nxt;
  logic       [WIDTH-1:0]   mem_r [DEPTH];
  logic                     push;
  logic                     pop;

  // flags and handshake
  assign o_in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data  = mem_r[st_r.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_r <= '0;
    end else if (i_enable) begin
      st_r <= st_nxt;
      if (push) begin
        mem_r[st_r.wp] <= i_in_data;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/sbst_tap.sv ***
`default_nettype none
// Contract
// R1 - unused port: controller holds test clock low, memory unaffected.
// R2 - unconnected mode select and serial input read as high.
// R3 - all test inputs sampled on test clock rising edge.
// R4 - serial output changes only on test clock falling edge.
// R5 - loaded instruction picks the register in the serial path.
// R6 - only one scan register in the serial path at once.
// R7 - input enters at MSB, output leaves from LSB.
// R8 - serial output driven only in shift states, else floating.
// R9 - five rising edges with mode select high reset test logic.
// R10 - test reset leaves memory operation undisturbed, accepted anytime.
// R11 - power-up resets test logic, serial output starts floating.
// R12 - instruction register three bits, loaded serially in its path.
// R13 - power-up and reset state load identification instruction.
// R14 - capture-instruction loads low two bits with 01.
// R15 - bypass path is one flip-flop, one bit delay.
// R16 - bypass flip-flop cleared when bypass instruction executes.
// R17 - capture-data loads I/O ring into boundary register, then shifts.
// R18 - extest, sample/preload, sample-z all capture the I/O ring.
// R19 - boundary register includes cells for unconnected balls.
// R20 - identification register: fixed 32-bit code, capture then shift.
// R21 - sample-z floats read-data outputs until next update-instruction.
// R22 - cell 108 enables read drivers under extest; presets high.
// R23 - standard sixteen-state controller; opcodes are parameters.
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [ID_WIDTH-1:0]  ID_CODE   = 32'h0000_0001, // arbitrary value
  parameter logic [2:0]           OPC_EXT   = OP_EXTEST,     // [R23]
  parameter logic [2:0]           OPC_ID    = OP_IDCODE,
  parameter logic [2:0]           OPC_SZ    = OP_SAMPLE_Z,
  parameter logic [2:0]           OPC_SMP   = OP_SAMPLE,
  parameter logic [2:0]           OPC_BYP   = OP_BYPASS,
  parameter int                   RING_W    = BSR_WIDTH
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_clock_en,
  input  wire logic              i_tck,
  input  wire logic              i_tms,
  input  wire logic              i_tdi,
  input  wire logic [RING_W-1:0] i_ring,
  output logic                   o_tdo,
  output logic                   o_tdo_oe,
  output logic      [RING_W-1:0] o_ring_preload,
  output logic                   o_extest,
  output logic                   o_q_oe,
  output logic                   o_cap_valid,
  output logic      [RING_W-1:0] o_cap_data
);
  typedef struct packed {
    logic [1:0]        tck_s;
    logic [1:0]        tms_s;
    logic [1:0]        tdi_s;
    logic              tck_d;
    sbst_state_t       state;
    logic [2:0]        ir;
    logic [2:0]        ir_sh;
    logic              byp;
    logic [ID_WIDTH-1:0] id_sh;
    logic [RING_W-1:0] bsr_sh;
    logic [RING_W-1:0] bsr_up;
    logic              hiz;
    logic              tdo;
    logic              tdo_oe;
    logic [RING_W-1:0] ring_smp;
    logic              extest;
    logic              q_oe;
  } sbst_tap_t;

  sbst_tap_t   st_r;
  sbst_tap_t   st_nxt;
  logic        rise;
  logic        fall;
  logic        tms;
  logic        tdi;
  logic        cap_push;
  logic        cap_ready;

  // next controller state from mode select
  function automatic sbst_state_t next_state(input sbst_state_t s, input logic m);
    case (s)
      ST_RESET:    next_state = m ? ST_RESET   : ST_IDLE;
      ST_IDLE:     next_state = m ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_DR:   next_state = m ? ST_SEL_IR  : ST_CAP_DR;
      ST_CAP_DR:   next_state = m ? ST_EX1_DR  : ST_SH_DR;
      ST_SH_DR:    next_state = m ? ST_EX1_DR  : ST_SH_DR;
      ST_EX1_DR:   next_state = m ? ST_UPD_DR  : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = m ? ST_EX2_DR  : ST_PAUSE_DR;
      ST_EX2_DR:   next_state = m ? ST_UPD_DR  : ST_SH_DR;
      ST_UPD_DR:   next_state = m ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_IR:   next_state = m ? ST_RESET   : ST_CAP_IR;
      ST_CAP_IR:   next_state = m ? ST_EX1_IR  : ST_SH_IR;
      ST_SH_IR:    next_state = m ? ST_EX1_IR  : ST_SH_IR;
      ST_EX1_IR:   next_state = m ? ST_UPD_IR  : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = m ? ST_EX2_IR  : ST_PAUSE_IR;
      ST_EX2_IR:   next_state = m ? ST_UPD_IR  : ST_SH_IR;
      default:     next_state = m ? ST_SEL_DR  : ST_IDLE;
    endcase
  endfunction

  // instruction decode helper for boundary-register users
  function automatic logic uses_bsr(input logic [2:0] op);
    uses_bsr = (op == OPC_EXT) || (op == OPC_SMP) || (op == OPC_SZ); // [R18]
  endfunction

  // synchronised pins and test clock edges; second stage only is read
  assign tms  = st_r.tms_s[1];
  assign tdi  = st_r.tdi_s[1];
  assign rise = st_r.tck_s[1] && !st_r.tck_d;                      // [R3]
  assign fall = !st_r.tck_s[1] && st_r.tck_d;                      // [R4]
  assign cap_push = rise && (st_r.state == ST_CAP_DR) && uses_bsr(st_r.ir) && cap_ready;

  // test logic next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.tck_s = {st_r.tck_s[0], i_tck};
    st_nxt.tms_s = {st_r.tms_s[0], i_tms};
    st_nxt.tdi_s = {st_r.tdi_s[0], i_tdi};
    st_nxt.tck_d = st_r.tck_s[1];
    if (rise) begin
      // five high edges from any state reach reset via the standard graph
      st_nxt.state = next_state(st_r.state, tms);                  // [R9] [R23] [R10]
      case (st_r.state)
        ST_CAP_IR: begin
          st_nxt.ir_sh = {st_r.ir[2], IR_CAPTURE_PAT};             // [R14]
        end
        ST_SH_IR: begin
          st_nxt.ir_sh = {tdi, st_r.ir_sh[2:1]};                   // [R7] [R12]
        end
        ST_UPD_IR: begin
          st_nxt.ir  = st_r.ir_sh;                                 // [R5]
          st_nxt.hiz = (st_r.ir_sh == OPC_SZ);                     // [R21]
          if (st_r.ir_sh == OPC_BYP) begin
            st_nxt.byp = 1'b0;                                     // [R16]
          end
        end
        ST_CAP_DR: begin
          if (st_r.ir == OPC_ID) begin
            st_nxt.id_sh = ID_CODE;                                // [R20]
          end else if (uses_bsr(st_r.ir)) begin
            st_nxt.bsr_sh   = i_ring;                              // [R17] [R19]
            st_nxt.ring_smp = i_ring;
          end else begin
            st_nxt.byp = 1'b0;                                     // [R16]
          end
        end
        ST_SH_DR: begin
          // exactly one data register moves per instruction
          if (st_r.ir == OPC_ID) begin
            st_nxt.id_sh = {tdi, st_r.id_sh[ID_WIDTH-1:1]};        // [R6] [R7]
          end else if (uses_bsr(st_r.ir)) begin
            st_nxt.bsr_sh = {tdi, st_r.bsr_sh[RING_W-1:1]};        // [R7]
          end else begin
            st_nxt.byp = tdi;                                      // [R15]
          end
        end
        ST_UPD_DR: begin
          if (uses_bsr(st_r.ir) && st_r.ir != OPC_SZ) begin
            st_nxt.bsr_up = st_r.bsr_sh;
          end
        end
        default: begin
        end
      endcase
    end
    // reset state holds identification and preset cell, no wait for a further edge
    if (st_r.state == ST_RESET) begin
      st_nxt.ir  = OPC_ID;                                         // [R13]
      st_nxt.hiz = 1'b0;
      st_nxt.bsr_up[BSR_OE_CELL] = 1'b1;                           // [R22]
    end
    // serial output moves on the falling edge only
    if (fall) begin
      st_nxt.tdo_oe = (st_r.state == ST_SH_DR) || (st_r.state == ST_SH_IR); // [R8]
      if (st_r.state == ST_SH_IR) begin
        st_nxt.tdo = st_r.ir_sh[0];                                // [R4] [R7]
      end else if (st_r.ir == OPC_ID) begin
        st_nxt.tdo = st_r.id_sh[0];
      end else if (uses_bsr(st_r.ir)) begin
        st_nxt.tdo = st_r.bsr_sh[0];
      end else begin
        st_nxt.tdo = st_r.byp;                                     // [R15]
      end
    end
    // registered pin controls follow the next instruction and cell 108
    st_nxt.extest = (st_nxt.ir == OPC_EXT);
    st_nxt.q_oe   = st_nxt.hiz ? 1'b0 :                            // [R21]
                    (st_nxt.extest ? st_nxt.bsr_up[BSR_OE_CELL] : 1'b1); // [R22]
  end

  // state register; reset stands in for the power-up reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_r                     <= '0;
      st_r.tck_s               <= 2'h0;                            // [R1]
      st_r.tms_s               <= 2'h3;                            // [R2]
      st_r.tdi_s               <= 2'h3;                            // [R2]
      st_r.state               <= ST_RESET;                        // [R11]
      st_r.ir                  <= OPC_ID;                          // [R13]
      st_r.bsr_up[BSR_OE_CELL] <= 1'b1;                            // [R22]
      st_r.tdo_oe              <= 1'b0;                            // [R11]
      st_r.extest              <= (OPC_ID == OPC_EXT);
      st_r.q_oe                <= 1'b1;                            // [R22]
    end else if (i_clock_en) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign o_tdo          = st_r.tdo;
  assign o_tdo_oe       = st_r.tdo_oe;
  assign o_ring_preload = st_r.bsr_up;
  assign o_extest       = st_r.extest;
  assign o_q_oe         = st_r.q_oe;                                // [R21] [R22]

  // captured ring snapshots queued for the memory side
  sbst_fifo #(
    .WIDTH (RING_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cap_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_enable    (i_clock_en),
    .i_in_valid  (cap_push),
    .o_in_ready  (cap_ready),
    .i_in_data   (i_ring),
    .o_out_valid (o_cap_valid),
    .i_out_ready (1'b1),
    .o_out_data  (o_cap_data)
  );
endmodule
`default_nettype wire

// *** tb/sbst_ctl_model.sv ***
`default_nettype none
module sbst_ctl_model (
  input  wire logic i_clock,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  // test clock parked low, idle pins float high
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one test clock: set pins while low, sample data out, rise, fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clock);
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clock);
    tdo = i_tdo;
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_tck <= 1'b0;
    o_tdi <= 1'b1;
  endtask
  // five rises with mode select high, then run-test idle
  task automatic test_reset;
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
endmodule
`default_nettype wire

// *** tb/sbst_tap_asserts.sv ***
`default_nettype none
module sbst_tap_asserts
  import sbst_pkg::*;
#(parameter int RING_W = BSR_WIDTH) (
  input wire logic              i_clock,
  input wire logic              i_reset,
  input wire logic              i_tck,
  input wire logic              i_tms,
  input wire logic              o_tdo,
  input wire logic              o_tdo_oe,
  input wire logic [RING_W-1:0] o_ring_preload,
  input wire logic              o_extest,
  input wire logic              o_q_oe,
  input wire logic              o_cap_valid
);
  logic       tck_q;
  logic [3:0] fall_n;
  logic [3:0] rise_n;
  logic [3:0] edge_n;
  logic [2:0] hi_n;
  wire logic  fell = tck_q && !i_tck;
  wire logic  rose = !tck_q && i_tck;
  // cycles since test clock edges, rises with mode select high
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tck_q  <= 1'b0;
      fall_n <= 4'hF;
      rise_n <= 4'hF;
      edge_n <= 4'hF;
      hi_n   <= 3'h0;
    end else begin
      tck_q  <= i_tck;
      fall_n <= fell ? 4'h0 : fall_n + {3'h0, fall_n != 4'hF};
      rise_n <= rose ? 4'h0 : rise_n + {3'h0, rise_n != 4'hF};
      edge_n <= (fell || rose) ? 4'h0 : edge_n + {3'h0, edge_n != 4'hF};
      hi_n   <= !rose ? hi_n : (i_tms ? hi_n + {2'h0, hi_n != 3'h7} : 3'h0);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  reset_out_a: assert property ($fell(i_reset) |->
    !o_tdo_oe && o_q_oe && o_ring_preload[BSR_OE_CELL] && !o_extest) else $error("reset outputs");
  tdo_fall_a: assert property ($changed(o_tdo) |-> fall_n < 4'h6)
    else $error("data out moved off falling edge");
  oe_fall_a: assert property ($changed(o_tdo_oe) |-> fall_n < 4'h6)
    else $error("out enable moved off falling edge");
  quiet_clock_a: assert property (edge_n == 4'hF |->
    $stable(o_tdo) && $stable(o_tdo_oe) && $stable(o_extest)) else $error("change with clock still");
  instr_rise_a: assert property ($changed(o_extest) |-> rise_n < 4'h6)
    else $error("instruction change off rising edge");
  preload_rise_a: assert property ($changed(o_ring_preload) |-> rise_n < 4'h6)
    else $error("preload change off rising edge");
  ext_drive_a: assert property ((o_extest && $stable(o_ring_preload))[*3] |->
    o_q_oe == o_ring_preload[BSR_OE_CELL]) else $error("read drivers not from cell");
  tms_reset_a: assert property (hi_n == 3'h5 |-> ##[1:6] (!o_extest && o_q_oe))
    else $error("mode select reset missed");
  cover property (o_extest && !o_q_oe);
  cover property (!o_extest && !o_q_oe);
  cover property (o_cap_valid);
endmodule
bind sbst_tap sbst_tap_asserts #(.RING_W(RING_W)) u_chk (.i_clock, .i_reset, .i_tck, .i_tms,
  .o_tdo, .o_tdo_oe, .o_ring_preload, .o_extest, .o_q_oe, .o_cap_valid);
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top
  import sbst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_VAL = 32'h1234_5679; // arbitrary value
  logic         i_clock = 1'b0;
  logic         i_reset = 1'b1;
  logic         tck, tms, tdi, tdo, tdo_oe, extest, q_oe, cap_valid;
  logic [108:0] ring = '0;
  logic [108:0] preload, cap_data, last_cap, din, dout;
  logic [2:0]   ops [3] = '{OP_SAMPLE, OP_SAMPLE_Z, OP_EXTEST};
  int           errors = 0;
  int           cmp_count = 0;
  int           cycles = 0;
  always #10 i_clock = ~i_clock;
  sbst_ctl_model ctl (.i_clock, .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  sbst_tap #(.ID_CODE(ID_VAL)) dut (.i_clock, .i_reset, .i_clock_en(1'b1), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_ring(ring), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .o_ring_preload(preload), .o_extest(extest), .o_q_oe(q_oe), .o_cap_valid(cap_valid),
    .o_cap_data(cap_data));
  task automatic report_and_stop;
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [108:0] got, input logic [108:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  // newest snapshot off the capture queue, and the hang limit
  always @(posedge i_clock) begin
    if (cap_valid) last_cap <= cap_data;
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errors++;
      report_and_stop;
    end
  end
  // idle -> capture -> shift n bits, lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [108:0] d,
                      output logic [108:0] q);
    logic t;
    q = '0;
    ctl.step(1'b1, 1'b1, t);
    if (ir) ctl.step(1'b1, 1'b1, t);
    ctl.step(1'b0, 1'b1, t);
    ctl.step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, d[i], q[i]);
      if (i == 0) check(tdo_oe, 1'b1, "out enable in shift");
    end
    ctl.step(1'b1, 1'b1, t);
    ctl.step(1'b0, 1'b1, t);
    repeat (5) @(posedge i_clock);
    check(tdo_oe, 1'b0, "out enable idle");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    check({tdo_oe, q_oe, preload[BSR_OE_CELL], extest}, 4'h6, "reset outputs");
    ctl.test_reset();
    scan(1'b0, ID_WIDTH, '0, dout);
    check(dout[31:0], ID_VAL, "id code");
    scan(1'b1, IR_WIDTH, {106'h0, OP_BYPASS}, dout);
    check(dout[1:0], IR_CAPTURE_PAT, "ir capture");
    scan(1'b0, 4, 109'hB, dout);
    check(dout[3:0], 4'h6, "bypass delay");
    for (int k = 0; k < 3; k++) begin
      ring <= {1'b1, {3{36'h96C3A5F1E}}} ^ {106'h0, ops[k]};
      din = {1'b0, {3{36'h3C5AE1F96}}};
      scan(1'b1, IR_WIDTH, {106'h0, ops[k]}, dout);
      scan(1'b0, BSR_WIDTH, din, dout);
      check(dout, ring, "ring capture");
      check(last_cap, ring, "capture queue");
      check(q_oe, ops[k] == OP_SAMPLE, "read drivers");
      check(extest, ops[k] == OP_EXTEST, "extest level");
      check(preload, din, "preload");
    end
    ctl.test_reset();
    check({extest, q_oe, preload[BSR_OE_CELL]}, 3'h3, "test reset");
    report_and_stop;
  end
endmodule
`default_nettype wire
